// ### rtl/edge_timer.sv
/*
  One phase offset measuring engine: counts system clocks from the latest
  rising edge of the faster signal to each rising edge of the other signal.
  Assumes both inputs are already sampled synchronously to clk_sys.
*/
`timescale 1ns/1ps
module edge_timer #(
  parameter int CNT_W = 24
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Control and signals
  input wire logic enable,
  input wire logic sig_ref,
  input wire logic sig_meas,
  // Result
  output logic [CNT_W-1:0] offset_cnt,
  output logic offset_valid
);

  logic ref_q_ff;
  logic meas_q_ff;
  logic ref_seen_ff;
  logic [CNT_W-1:0] run_ff;
  logic [CNT_W-1:0] per_ff;
  logic ref_rise;
  logic meas_rise;
  logic [CNT_W-1:0] nxt_offset;

  if (CNT_W < 8 || CNT_W > 40) begin : g_chk
    $error("edge_timer: CNT_W out of range");
  end

  // Edge history of both signals
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      ref_q_ff <= 1'b0;
      meas_q_ff <= 1'b0;
    end
    else
    begin
      ref_q_ff <= sig_ref;
      meas_q_ff <= sig_meas;
    end
  end

  assign ref_rise = sig_ref & ~ref_q_ff;
  assign meas_rise = sig_meas & ~meas_q_ff;

  // Running count since the last reference edge, and the shortest reference period seen
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      run_ff <= '0;
      per_ff <= '0;
      ref_seen_ff <= 1'b0;
    end
    else if (!enable)
    begin
      run_ff <= '0;
      per_ff <= '0;
      ref_seen_ff <= 1'b0;
    end
    else if (ref_rise)
    begin
      run_ff <= '0;
      // A gap leaves a long run; keep the shorter, true period
      if (!ref_seen_ff || per_ff == '0 || run_ff + 1'b1 < per_ff)
        per_ff <= ref_seen_ff ? CNT_W'(run_ff + 1'b1) : '0;
      ref_seen_ff <= 1'b1;
    end
    else if (run_ff != '1)
      run_ff <= CNT_W'(run_ff + 1'b1);
  end

  // Fold a reading that ran past a missing reference edge back into one period
  assign nxt_offset = (ref_rise || !ref_seen_ff) ? '0 :
                      (per_ff != '0 && run_ff + 1'b1 >= per_ff) ?
                      CNT_W'(run_ff + 1'b1 - per_ff) : CNT_W'(run_ff + 1'b1);

  // Offset capture on each rising edge of the measured signal
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      offset_cnt <= '0;
      offset_valid <= 1'b0;
    end
    else if (!enable)
      offset_valid <= 1'b0;
    else if (meas_rise && ref_seen_ff)
    begin
      offset_cnt <= nxt_offset;
      offset_valid <= 1'b1;
    end
  end

  chk_idle_no_result: assert property (@(posedge clk_sys) disable iff (!resetn)
    !enable |=> !offset_valid)
    else $error("tool result valid while disabled");

  chk_offset_in_period: assert property (@(posedge clk_sys) disable iff (!resetn)
    (enable && meas_rise && ref_seen_ff && per_ff != '0 && !ref_rise) |=>
    offset_cnt < $past(per_ff))
    else $error("offset exceeds reference period");

endmodule : edge_timer

// ### rtl/input_phase_offset_measure.sv
/*
  Input-side phase measurement: regular and low-frequency input-to-input
  phase offset tools, a shared read request, per-input phase adjustment and
  the per-DPLL input phase error report.
  Assumes all pins and host strobes are synchronous to clk_sys and that the
  DPLL core supplies its phase error and lock/pull-in flags.
*/
// How it works
// - After reset all ten inputs are single ended; each pos/neg pair may be set differential.
// - Two independent tools each pick any two of ten references and two synth feedbacks.
// - Both tools report phase offset in units of 0.01 ps.
// - The measurable offset spans one period of the faster clock.
// - Setting bit 0 of a tool's own control register starts that tool.
// - Setting the read-request bit latches results and the device clears the bit.
// - One read-request bit serves both tools.
// - Low-frequency results exclude per-input phase compensation.
// - Each DPLL's 48-bit input phase error is reported while locked or pulling in.
// - Each input has its own 1 ps phase adjustment limited to plus or minus 2.1 ms.
// - Measurement keeps working on gapped reference clocks.
`timescale 1ns/1ps
module input_phase_offset_measure #(
  parameter int NUM_DPLL = 3,
  parameter int REG_CNT_W = 16,
  parameter int LF_CNT_W = 28
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Reference pins and synthesizer feedback
  input wire logic [phase_meas_pkg::NUM_PAIRS-1:0] ref_input_pos,
  input wire logic [phase_meas_pkg::NUM_PAIRS-1:0] ref_input_neg,
  input wire logic [phase_meas_pkg::NUM_SYNTH_FB-1:0] synth_fb,
  // Input format configuration
  input wire logic cfg_we,
  input wire logic [phase_meas_pkg::NUM_PAIRS-1:0] cfg_diff_pairs,
  // Tool selection and control
  input wire phase_meas_pkg::ref_sel_s reg_sel,
  input wire phase_meas_pkg::ref_sel_s lf_sel,
  input wire logic reg_ctrl_we,
  input wire logic [7:0] reg_ctrl_data,
  input wire logic lf_ctrl_we,
  input wire logic [7:0] lf_ctrl_data,
  // Shared read request and phase adjustment writes
  input wire logic rd_req_we,
  input wire logic [7:0] rd_req_data,
  input wire phase_meas_pkg::comp_wr_s comp_wr,
  // DPLL core status
  input wire logic [phase_meas_pkg::DATA_W-1:0] dpll_err_in [NUM_DPLL],
  input wire logic [NUM_DPLL-1:0] dpll_locked,
  input wire logic [NUM_DPLL-1:0] dpll_pullin,
  // Register read-back
  output logic [phase_meas_pkg::NUM_PAIRS-1:0] diff_pairs_ff,
  output logic [7:0] reg_ctrl_ff,
  output logic [7:0] lf_ctrl_ff,
  output logic rd_req_ff,
  output logic [phase_meas_pkg::DATA_W-1:0] reg_data_ff,
  output logic [phase_meas_pkg::DATA_W-1:0] lf_data_ff,
  output logic [phase_meas_pkg::DATA_W-1:0] dpll_input_phase_error_ff [NUM_DPLL]
);

  logic [2*phase_meas_pkg::IDX_W-1:0] reg_idx_ff;
  logic [2*phase_meas_pkg::IDX_W-1:0] lf_idx_ff;
  logic [phase_meas_pkg::NUM_SIG-1:0] sig_vec;
  logic [REG_CNT_W-1:0] reg_cnt;
  logic [LF_CNT_W-1:0] lf_cnt;
  logic reg_valid;
  logic lf_valid;
  logic signed [phase_meas_pkg::COMP_W-1:0] comp_hi;
  logic signed [phase_meas_pkg::COMP_W-1:0] comp_lo;
  logic [phase_meas_pkg::DATA_W-1:0] reg_result;
  logic [phase_meas_pkg::DATA_W-1:0] lf_result;
  logic nxt_rd_req;
  logic cfg_seen_ff;

  if (NUM_DPLL < 1 || NUM_DPLL > 3 || REG_CNT_W < 8 || LF_CNT_W < REG_CNT_W
      || LF_CNT_W > 40) begin : g_chk
    $error("input_phase_offset_measure: parameter out of range");
  end

  // Pick one signal of the twelve by index; unused indices read low
  function automatic logic pick_sig(input logic [phase_meas_pkg::IDX_W-1:0] idx,
                                    input logic [phase_meas_pkg::NUM_SIG-1:0] v);
    if (idx < phase_meas_pkg::IDX_W'(phase_meas_pkg::NUM_SIG))
      return v[idx];
    else
      return 1'b0;
  endfunction : pick_sig

  // Cycle count to 0.01 ps units
  function automatic logic [phase_meas_pkg::DATA_W-1:0] to_units(
    input logic [phase_meas_pkg::DATA_W-1:0] cnt);
    return phase_meas_pkg::DATA_W'(cnt * phase_meas_pkg::UNITS_PER_CYCLE);
  endfunction : to_units

  // Input format register, single ended from reset
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      diff_pairs_ff <= phase_meas_pkg::DIFF_PAIRS_RST;
      cfg_seen_ff <= 1'b0;
    end
    else if (cfg_we)
    begin
      diff_pairs_ff <= cfg_diff_pairs;
      cfg_seen_ff <= 1'b1;
    end
  end

  // Signal vector: index 2k is pos pin k, 2k+1 neg pin k, then synth feedback
  always_comb
  begin
    for (int k = 0; k < phase_meas_pkg::NUM_PAIRS; k++)
    begin
      // A differential pair is seen on its pos index; the neg index reads low
      sig_vec[2*k] = diff_pairs_ff[k] ? (ref_input_pos[k] & ~ref_input_neg[k])
                                      : ref_input_pos[k];
      sig_vec[2*k+1] = diff_pairs_ff[k] ? 1'b0 : ref_input_neg[k];
    end
    for (int f = 0; f < phase_meas_pkg::NUM_SYNTH_FB; f++)
      sig_vec[phase_meas_pkg::NUM_REFS+f] = synth_fb[f];
  end

  // Select registers, high index names the faster signal
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      reg_idx_ff <= '0;
      lf_idx_ff <= '0;
    end
    else
    begin
      if (reg_sel.we)
        reg_idx_ff <= {reg_sel.idx_hi, reg_sel.idx_lo};
      if (lf_sel.we)
        lf_idx_ff <= {lf_sel.idx_hi, lf_sel.idx_lo};
    end
  end

  // Separate control register per tool; bit 0 enables
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      reg_ctrl_ff <= phase_meas_pkg::CTRL_RST;
      lf_ctrl_ff <= phase_meas_pkg::CTRL_RST;
    end
    else
    begin
      if (reg_ctrl_we)
        reg_ctrl_ff <= reg_ctrl_data;
      if (lf_ctrl_we)
        lf_ctrl_ff <= lf_ctrl_data;
    end
  end

  // Regular tool, short counter for faster signals
  edge_timer #(
    .CNT_W(REG_CNT_W)
  ) u_reg_tool (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .enable(reg_ctrl_ff[phase_meas_pkg::CTRL_EN_BIT]),
    .sig_ref(pick_sig(reg_idx_ff[2*phase_meas_pkg::IDX_W-1:phase_meas_pkg::IDX_W], sig_vec)),
    .sig_meas(pick_sig(reg_idx_ff[phase_meas_pkg::IDX_W-1:0], sig_vec)),
    .offset_cnt(reg_cnt),
    .offset_valid(reg_valid)
  );

  // Low-frequency tool, wide counter for sub-8 kHz signals
  edge_timer #(
    .CNT_W(LF_CNT_W)
  ) u_lf_tool (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .enable(lf_ctrl_ff[phase_meas_pkg::CTRL_EN_BIT]),
    .sig_ref(pick_sig(lf_idx_ff[2*phase_meas_pkg::IDX_W-1:phase_meas_pkg::IDX_W], sig_vec)),
    .sig_meas(pick_sig(lf_idx_ff[phase_meas_pkg::IDX_W-1:0], sig_vec)),
    .offset_cnt(lf_cnt),
    .offset_valid(lf_valid)
  );

  // Per-input phase adjustment store
  phase_adjust u_adjust (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .comp_wr(comp_wr),
    .rd_idx_a(reg_idx_ff[2*phase_meas_pkg::IDX_W-1:phase_meas_pkg::IDX_W]),
    .rd_idx_b(reg_idx_ff[phase_meas_pkg::IDX_W-1:0]),
    .comp_a(comp_hi),
    .comp_b(comp_lo)
  );

  // Results in 0.01 ps; the regular tool applies the adjustment difference
  assign reg_result = phase_meas_pkg::DATA_W'(to_units(phase_meas_pkg::DATA_W'(reg_cnt))
                      + phase_meas_pkg::DATA_W'((comp_lo - comp_hi)
                      * phase_meas_pkg::UNITS_PER_PS));
  assign lf_result = to_units(phase_meas_pkg::DATA_W'(lf_cnt));

  // Read request: a new set in the clearing cycle wins over the clear
  assign nxt_rd_req = rd_req_we & rd_req_data[phase_meas_pkg::RD_REQ_BIT];

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      rd_req_ff <= 1'b0;
    else
      rd_req_ff <= nxt_rd_req;
  end

  // Data registers load only while the shared request is serviced
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      reg_data_ff <= '0;
      lf_data_ff <= '0;
    end
    else if (rd_req_ff)
    begin
      if (reg_valid)
        reg_data_ff <= reg_result;
      if (lf_valid)
        lf_data_ff <= lf_result;
    end
  end

  // DPLL input phase error tracks the core while locked or pulling in
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int d = 0; d < NUM_DPLL; d++)
        dpll_input_phase_error_ff[d] <= '0;
    end
    else
    begin
      for (int d = 0; d < NUM_DPLL; d++)
        if (dpll_locked[d] || dpll_pullin[d])
          dpll_input_phase_error_ff[d] <= dpll_err_in[d];
    end
  end

  chk_reset_single_end: assert property (@(posedge clk_sys) disable iff (!resetn)
    !cfg_seen_ff |-> diff_pairs_ff == phase_meas_pkg::DIFF_PAIRS_RST)
    else $error("inputs not single ended before configuration");

  chk_req_self_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
    rd_req_ff && !(rd_req_we && rd_req_data[phase_meas_pkg::RD_REQ_BIT]) |=> !rd_req_ff)
    else $error("read request bit not cleared");

  chk_req_latch_reg: assert property (@(posedge clk_sys) disable iff (!resetn)
    rd_req_ff && reg_valid |=> reg_data_ff == $past(reg_result))
    else $error("regular result not latched on request");

  chk_shared_req_both: assert property (@(posedge clk_sys) disable iff (!resetn)
    rd_req_ff && reg_valid && lf_valid |=>
    reg_data_ff == $past(reg_result) && lf_data_ff == $past(lf_result))
    else $error("shared request did not serve both tools");

  chk_lf_no_comp: assert property (@(posedge clk_sys) disable iff (!resetn)
    rd_req_ff && lf_valid |=>
    lf_data_ff == phase_meas_pkg::DATA_W'($past(lf_cnt) * phase_meas_pkg::UNITS_PER_CYCLE))
    else $error("low-frequency result carries compensation");

  chk_unit_scaling: assert property (@(posedge clk_sys) disable iff (!resetn)
    rd_req_ff && reg_valid |=>
    reg_data_ff == phase_meas_pkg::DATA_W'($past(reg_cnt) * phase_meas_pkg::UNITS_PER_CYCLE)
    + phase_meas_pkg::DATA_W'(($past(comp_lo) - $past(comp_hi))
    * phase_meas_pkg::UNITS_PER_PS))
    else $error("regular result not in 0.01 ps units");

  chk_data_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
    !rd_req_ff |=> $stable(reg_data_ff) && $stable(lf_data_ff))
    else $error("data changed without a read request");

  chk_dpll_track: assert property (@(posedge clk_sys) disable iff (!resetn)
    (dpll_locked[0] || dpll_pullin[0]) |=>
    dpll_input_phase_error_ff[0] == $past(dpll_err_in[0]))
    else $error("DPLL phase error not reported");

  chk_dpll_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
    !(dpll_locked[0] || dpll_pullin[0]) |=> $stable(dpll_input_phase_error_ff[0]))
    else $error("DPLL phase error changed while unlocked");

  chk_start_enable: assert property (@(posedge clk_sys) disable iff (!resetn)
    reg_ctrl_we |=> reg_ctrl_ff[phase_meas_pkg::CTRL_EN_BIT] == $past(reg_ctrl_data[0]))
    else $error("regular tool enable not taken");

  cov_reg_read: cover property (@(posedge clk_sys) disable iff (!resetn)
    reg_valid && nxt_rd_req ##1 rd_req_ff ##1 !rd_req_ff);
  cov_lf_read: cover property (@(posedge clk_sys) disable iff (!resetn)
    lf_valid && rd_req_ff);
  cov_diff_input: cover property (@(posedge clk_sys) disable iff (!resetn)
    diff_pairs_ff != '0 && reg_valid);
  cov_dpll_pullin: cover property (@(posedge clk_sys) disable iff (!resetn)
    dpll_pullin[0] && !dpll_locked[0]);

endmodule : input_phase_offset_measure

// ### rtl/phase_adjust.sv
/*
  Per-input phase adjustment store: one signed ps value for each of the ten
  reference inputs, clamped to the allowed range on write.
  Assumes writes come synchronously from the host side of clk_sys.
*/
`timescale 1ns/1ps
module phase_adjust (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Host write
  input wire phase_meas_pkg::comp_wr_s comp_wr,
  // Read ports for the two signals of the regular tool
  input wire logic [phase_meas_pkg::IDX_W-1:0] rd_idx_a,
  input wire logic [phase_meas_pkg::IDX_W-1:0] rd_idx_b,
  output logic signed [phase_meas_pkg::COMP_W-1:0] comp_a,
  output logic signed [phase_meas_pkg::COMP_W-1:0] comp_b
);

  logic signed [phase_meas_pkg::COMP_W-1:0] comp_ff [phase_meas_pkg::NUM_REFS];

  // Clamp a requested adjustment into the legal range
  function automatic logic signed [phase_meas_pkg::COMP_W-1:0] clamp_comp(
    input logic signed [phase_meas_pkg::COMP_W-1:0] v);
    if (v > phase_meas_pkg::COMP_MAX_PS)
      return phase_meas_pkg::COMP_MAX_PS;
    else if (v < -phase_meas_pkg::COMP_MAX_PS)
      return -phase_meas_pkg::COMP_MAX_PS;
    else
      return v;
  endfunction : clamp_comp

  // Reads outside the reference range (synth feedback) carry no adjustment
  function automatic logic signed [phase_meas_pkg::COMP_W-1:0] read_comp(
    input logic [phase_meas_pkg::IDX_W-1:0] idx,
    input logic signed [phase_meas_pkg::COMP_W-1:0] mem [phase_meas_pkg::NUM_REFS]);
    if (idx < phase_meas_pkg::IDX_W'(phase_meas_pkg::NUM_REFS))
      return mem[idx];
    else
      return '0;
  endfunction : read_comp

  // Independent storage per input
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < phase_meas_pkg::NUM_REFS; i++)
        comp_ff[i] <= '0;
    end
    else if (comp_wr.we && comp_wr.idx < phase_meas_pkg::IDX_W'(phase_meas_pkg::NUM_REFS))
      comp_ff[comp_wr.idx] <= clamp_comp(comp_wr.value);
  end

  assign comp_a = read_comp(rd_idx_a, comp_ff);
  assign comp_b = read_comp(rd_idx_b, comp_ff);

  chk_comp_clamped: assert property (@(posedge clk_sys) disable iff (!resetn)
    comp_wr.we && comp_wr.idx == 4'h0 |=>
    comp_ff[0] <= phase_meas_pkg::COMP_MAX_PS && comp_ff[0] >= -phase_meas_pkg::COMP_MAX_PS)
    else $error("phase adjustment outside range");

endmodule : phase_adjust

// ### rtl/phase_meas_pkg.sv
/*
  Shared constants and carriers for the input phase offset measurement block.
  Assumes a single 20 MHz system clock; all values are in that clock's units
  unless their name says otherwise.
*/
package phase_meas_pkg;

  // Signal set seen by the tools: ten reference pins plus two synth feedbacks
  localparam int NUM_REFS = 10;
  localparam int NUM_PAIRS = 5;
  localparam int NUM_SYNTH_FB = 2;
  localparam int NUM_SIG = 12;
  localparam int IDX_W = 4;

  // Result and compensation widths
  localparam int DATA_W = 48;
  localparam int COMP_W = 33;

  // Bit positions in the host-written control words
  localparam int CTRL_EN_BIT = 0;
  localparam int RD_REQ_BIT = 0;

  // Reset values
  localparam logic [4:0] DIFF_PAIRS_RST = 5'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // Timing: clock period in ps and the 0.01 ps result unit
  localparam longint CLK_PERIOD_PS = 50000;
  localparam longint UNITS_PER_PS = 100;
  localparam logic [DATA_W-1:0] UNITS_PER_CYCLE = DATA_W'(CLK_PERIOD_PS * UNITS_PER_PS);

  // Input phase adjustment limit, 2.1 ms expressed in ps
  localparam longint COMP_MAX_MS_X10 = 21;
  localparam longint PS_PER_MS = 1000000000;
  localparam logic signed [COMP_W-1:0] COMP_MAX_PS = COMP_W'(COMP_MAX_MS_X10 * PS_PER_MS / 10);

  // Signal pair selection written by the host for one tool
  typedef struct packed {
    logic we;
    logic [IDX_W-1:0] idx_hi;
    logic [IDX_W-1:0] idx_lo;
  } ref_sel_s;

  // Write of one input's phase adjustment, signed ps
  typedef struct packed {
    logic we;
    logic [IDX_W-1:0] idx;
    logic signed [COMP_W-1:0] value;
  } comp_wr_s;

endpackage : phase_meas_pkg

// ### sim/input_phase_offset_measure_test.sv
/*
  Self-checking bench for the input phase offset measurement block.
  Assumes the reference clock source model drives pos pins of pairs 0 and 1.
*/
`timescale 1ns/1ps
module input_phase_offset_measure_test;
  localparam int NUM_DPLL = 3;
  localparam longint U = phase_meas_pkg::CLK_PERIOD_PS * phase_meas_pkg::UNITS_PER_PS;
  logic clk_sys, resetn, cfg_we, reg_ctrl_we, lf_ctrl_we, rd_req_we, sig_hi, sig_lo;
  logic [4:0] ref_input_neg, cfg_diff_pairs, diff_pairs_ff;
  logic [1:0] synth_fb;
  logic [7:0] reg_ctrl_data, lf_ctrl_data, rd_req_data, reg_ctrl_ff, lf_ctrl_ff;
  logic [7:0] src_period, src_delay;
  logic src_gap;
  phase_meas_pkg::ref_sel_s reg_sel, lf_sel;
  phase_meas_pkg::comp_wr_s comp_wr;
  logic [47:0] dpll_err_in [NUM_DPLL];
  logic [47:0] dpll_input_phase_error_ff [NUM_DPLL];
  logic [2:0] dpll_locked, dpll_pullin;
  logic rd_req_ff;
  logic [47:0] reg_data_ff, lf_data_ff;
  int mismatches, check_count, cycles;

  ref_clock_source src (.clk_sys(clk_sys), .resetn(resetn), .period(src_period),
    .delay(src_delay), .gap(src_gap), .sig_hi(sig_hi), .sig_lo(sig_lo));

  input_phase_offset_measure uut (.clk_sys(clk_sys), .resetn(resetn),
    .ref_input_pos({3'h0, sig_lo, sig_hi}), .ref_input_neg(ref_input_neg),
    .synth_fb(synth_fb), .cfg_we(cfg_we), .cfg_diff_pairs(cfg_diff_pairs),
    .reg_sel(reg_sel), .lf_sel(lf_sel), .reg_ctrl_we(reg_ctrl_we),
    .reg_ctrl_data(reg_ctrl_data), .lf_ctrl_we(lf_ctrl_we), .lf_ctrl_data(lf_ctrl_data),
    .rd_req_we(rd_req_we), .rd_req_data(rd_req_data), .comp_wr(comp_wr),
    .dpll_err_in(dpll_err_in), .dpll_locked(dpll_locked), .dpll_pullin(dpll_pullin),
    .diff_pairs_ff(diff_pairs_ff), .reg_ctrl_ff(reg_ctrl_ff), .lf_ctrl_ff(lf_ctrl_ff),
    .rd_req_ff(rd_req_ff), .reg_data_ff(reg_data_ff), .lf_data_ff(lf_data_ff),
    .dpll_input_phase_error_ff(dpll_input_phase_error_ff));

  // Clock generation
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish

  task check(input logic [47:0] seen, input logic [47:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Pulse one shared read request and follow the bit until it clears
  task read_request;
    @(posedge clk_sys);
    rd_req_we <= 1'b1;
    rd_req_data <= 8'h01;
    @(posedge clk_sys);
    rd_req_we <= 1'b0;
    #1 check(48'(rd_req_ff), 48'h1);
    @(posedge clk_sys);
    #1 check(48'(rd_req_ff), 48'h0);
  endtask : read_request

  task write_comp(input logic [3:0] idx, input logic signed [32:0] value);
    @(posedge clk_sys);
    comp_wr <= {1'b1, idx, value};
    @(posedge clk_sys);
    comp_wr.we <= 1'b0;
  endtask : write_comp

  // Format, control and data registers come out of reset cleared, inputs single ended
  task t_reset;
    check(48'(diff_pairs_ff), 48'h0);
    check(48'(reg_ctrl_ff), 48'h0);
    check(48'(lf_ctrl_ff), 48'h0);
    check(reg_data_ff, 48'h0);
    check(lf_data_ff, 48'h0);
  endtask : t_reset

  // Differential pair configuration is stored and read back
  task t_config;
    @(posedge clk_sys);
    cfg_we <= 1'b1;
    cfg_diff_pairs <= 5'h15;
    @(posedge clk_sys);
    cfg_we <= 1'b0;
    #1 check(48'(diff_pairs_ff), 48'h15);
    @(posedge clk_sys);
    cfg_we <= 1'b1;
    cfg_diff_pairs <= 5'h00;
    @(posedge clk_sys);
    cfg_we <= 1'b0;
  endtask : t_config

  // Both tools on pos0 against pos1 at 2.5 MHz, three cycles apart
  task t_measure;
    write_comp(4'h2, 33'sd7);
    @(posedge clk_sys);
    reg_sel <= {1'b1, 4'h0, 4'h2};
    lf_sel <= {1'b1, 4'h0, 4'h2};
    @(posedge clk_sys);
    reg_sel.we <= 1'b0;
    lf_sel.we <= 1'b0;
    reg_ctrl_we <= 1'b1;
    reg_ctrl_data <= 8'h01;
    lf_ctrl_we <= 1'b1;
    lf_ctrl_data <= 8'h01;
    @(posedge clk_sys);
    reg_ctrl_we <= 1'b0;
    lf_ctrl_we <= 1'b0;
    #1 check(48'(reg_ctrl_ff), 48'h1);
    check(48'(lf_ctrl_ff), 48'h1);
    repeat (48) @(posedge clk_sys);
    read_request;
    check(reg_data_ff, 48'(3 * U + 700));
    check(lf_data_ff, 48'(3 * U));
  endtask : t_measure

  // Results hold without a request; a disabled tool keeps its old result
  task t_hold;
    @(posedge clk_sys);
    src_delay <= 8'h05;
    lf_ctrl_we <= 1'b1;
    lf_ctrl_data <= 8'h00;
    @(posedge clk_sys);
    lf_ctrl_we <= 1'b0;
    repeat (48) @(posedge clk_sys);
    check(reg_data_ff, 48'(3 * U + 700));
    read_request;
    check(reg_data_ff, 48'(5 * U + 700));
    check(lf_data_ff, 48'(3 * U));
  endtask : t_hold

  // One missing leading edge; a reading taken across the gap is folded back
  task t_gap;
    @(posedge sig_hi);
    @(posedge clk_sys);
    src_gap <= 1'b1;
    repeat (8) @(posedge clk_sys);
    src_gap <= 1'b0;
    repeat (4) @(posedge clk_sys);
    read_request;
    check(reg_data_ff, 48'(5 * U + 700));
  endtask : t_gap

  // Adjustments past either limit are clamped to 2.1 ms
  task t_clamp;
    write_comp(4'h2, 33'h0_ffff_ffff);
    repeat (24) @(posedge clk_sys);
    read_request;
    check(reg_data_ff, 48'(5 * U + 64'd2100000000 * 100));
    write_comp(4'h0, -33'sd4000000000);
    read_request;
    check(reg_data_ff, 48'(5 * U + 64'd4200000000 * 100));
  endtask : t_clamp

  // Phase error follows the core while locked or pulling in, else holds
  task t_dpll;
    @(posedge clk_sys);
    dpll_err_in[0] <= 48'h1234_5678_9abc;
    dpll_err_in[1] <= 48'h0fed_cba9_8765;
    dpll_err_in[2] <= 48'h0000_0000_0042;
    dpll_locked <= 3'h1;
    dpll_pullin <= 3'h2;
    repeat (2) @(posedge clk_sys);
    dpll_locked <= 3'h0;
    dpll_pullin <= 3'h0;
    dpll_err_in[0] <= 48'h0000_0000_0001;
    #1 check(dpll_input_phase_error_ff[0], 48'h1234_5678_9abc);
    check(dpll_input_phase_error_ff[1], 48'h0fed_cba9_8765);
    check(dpll_input_phase_error_ff[2], 48'h0);
    repeat (3) @(posedge clk_sys);
    #1 check(dpll_input_phase_error_ff[0], 48'h1234_5678_9abc);
  endtask : t_dpll

  // Hang guard
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      mismatches++;
      tally_and_finish;
    end
  end

  // Main sequence
  initial
  begin
    {resetn, cfg_we, reg_ctrl_we, lf_ctrl_we, rd_req_we} = '0;
    {ref_input_neg, synth_fb, cfg_diff_pairs} = '0;
    {reg_ctrl_data, lf_ctrl_data, rd_req_data} = '0;
    {reg_sel, lf_sel, comp_wr, dpll_locked, dpll_pullin} = '0;
    dpll_err_in = '{default: 48'h0};
    src_period = 8'h08;
    src_delay = 8'h03;
    src_gap = 1'b0;
    {mismatches, check_count, cycles} = '0;
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    #1 t_reset;
    t_config;
    t_measure;
    t_hold;
    t_gap;
    t_clamp;
    t_dpll;
    tally_and_finish;
  end
endmodule : input_phase_offset_measure_test

// ### sim/ref_clock_source.sv
/*
  Reference clock source model: two frequency-locked square waves of one
  period, the second lagging the first by a set number of clk_sys cycles.
  A gap request drops whole periods of the leading wave.
  Assumes period and delay change only while no read is pending.
*/
`timescale 1ns/1ps
module ref_clock_source (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Waveform setup in clk_sys cycles
  input wire logic [7:0] period,
  input wire logic [7:0] delay,
  input wire logic gap,
  // Clock outputs
  output logic sig_hi,
  output logic sig_lo
);
  logic [7:0] phase_ff;
  logic [7:0] lag;
  logic gap_ff;

  // Gap taken only at a period boundary, so no stray leading edge appears
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      gap_ff <= 1'b0;
    else if (phase_ff >= period - 8'h01)
      gap_ff <= gap;
  end

  // Phase counter shared by both waves keeps them frequency locked
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      phase_ff <= 8'h00;
    else if (phase_ff >= period - 8'h01)
      phase_ff <= 8'h00;
    else
      phase_ff <= phase_ff + 8'h01;
  end

  // Lagging wave; equal rates, so the leading one may be the first index
  assign lag = (phase_ff >= delay) ? phase_ff - delay : phase_ff + period - delay;
  assign sig_hi = resetn && !gap_ff && (phase_ff < (period >> 1));
  assign sig_lo = resetn && (lag < (period >> 1));
endmodule : ref_clock_source
